// ==== logic/scl_pkg.sv ====
// constants, types and register map of the serial bus controller
package scl_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [4:0] SCL_OFS_TX_LO = 5'h00;
  localparam logic [4:0] SCL_OFS_TX_HI = 5'h04;
  localparam logic [4:0] SCL_OFS_RX = 5'h08;
  localparam logic [4:0] SCL_OFS_STAT = 5'h0C;
  localparam logic [4:0] SCL_OFS_START = 5'h10;
  localparam logic [4:0] SCL_OFS_EVT_STS = 5'h14;
  localparam logic [4:0] SCL_OFS_EVT_MASK = 5'h18;

  // status register fields
  localparam int SCL_STAT_DIV_LSB = 0;
  localparam int SCL_STAT_INTEN_BIT = 2;
  localparam int SCL_STAT_BUSY_BIT = 3;
  localparam int SCL_STAT_ACKB_BIT = 4;

  // divider ratio codes: 1/2, 1/4, 1/8, 1/16
  localparam logic [1:0] SCL_DIV_2 = 2'h0;
  localparam logic [1:0] SCL_DIV_4 = 2'h1;
  localparam logic [1:0] SCL_DIV_8 = 2'h2;
  localparam logic [1:0] SCL_DIV_16 = 2'h3;

  // values after reset
  localparam logic [1:0] SCL_DIV_RST = SCL_DIV_2;
  localparam logic SCL_INTEN_RST = 1'b0;
  localparam logic SCL_ACKB_RST = 1'b1;
  localparam logic [15:0] SCL_TX_RST = 16'h0000;
  localparam logic [7:0] SCL_RX_RST = 8'h00;

  // event status bits
  localparam int SCL_EVT_W = 2;
  localparam int SCL_EVT_DONE = 0;
  localparam int SCL_EVT_CANCEL = 1;
  localparam logic [SCL_EVT_W-1:0] SCL_EVT_RST = 2'h0;

  // frame shape, counted in shift clock edges and half periods
  localparam logic [4:0] SCL_TX_BITS = 5'h10;
  localparam logic [4:0] SCL_RX_FIRST = 5'h08;
  localparam logic [4:0] SCL_TAIL_TICKS = 5'h02;

  // write processing bound, in input clock periods
  localparam int SCL_CLK_PERIOD_NS = 4;
  localparam int SCL_WR_PROC_TC = 5;
  localparam int SCL_WR_PROC_CYC = SCL_WR_PROC_TC * SCL_CLK_PERIOD_NS / SCL_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SCL_ST_IDLE = 2'h0,
    SCL_ST_LEAD = 2'h1,
    SCL_ST_SHIFT = 2'h3,
    SCL_ST_TAIL = 2'h2
  } scl_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scl_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } scl_wb_rsp_t;

  typedef struct packed {
    logic sclk;
    logic serial_data_out;
    logic oe_n;
  } scl_ser_t;

endpackage

// ==== logic/scl_clkdiv.sv ====
// half-period tick generator for the shift clock
`timescale 1ns/10ps
module scl_clkdiv (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] ratio_i,
  output logic tick_o
);
  import scl_pkg::*;

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] lim;

  // half period is 1, 2, 4 or 8 input clocks
  assign lim = 3'((4'h1 << ratio_i) - 4'h1);
  assign tick_o = run_i & (cnt_r == lim);

  always_comb begin
    cnt_nxt = 3'h0;
    if (run_i && !tick_o) begin
      cnt_nxt = cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // scl_clkdiv

// ==== logic/scl_ctrl.sv ====
// serial bus controller: shift clock, frame, interrupt and reset handling
// Functional notes
// - the shift clock is the input clock divided by 2, 4, 8 or 16 as selected.
// - with interrupts enabled the interrupt pin goes high when a serial cycle ends.
// - any host read returns a high interrupt pin to low, unless a serial cycle ends in the same clock.
// - with interrupts disabled the interrupt pin stays low.
// - during reset output enable, shift clock and serial data out sit high.
// - reset clears busy, sets the acknowledge bit, disables the interrupt, selects 1/2.
// - a host write is fully processed within five input clock periods.
// - one bit time after the sixteenth rise the pins go idle, busy drops, an enabled interrupt rises.
// - a write to the status register loads the divider ratio and interrupt enable.
`timescale 1ns/10ps
module scl_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire scl_pkg::scl_wb_req_t wb_req_i,
  output scl_pkg::scl_wb_rsp_t wb_rsp_o,
  input wire logic serial_data_in_i,
  output scl_pkg::scl_ser_t ser_o,
  output logic int_o,
  output logic irq_o
);
  import scl_pkg::*;

  // bus side state
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic [1:0] div_sel_r, div_sel_nxt;
  logic int_en_r, int_en_nxt;
  logic int_flag_r, int_flag_nxt;
  logic armed_r, armed_nxt;
  logic [SCL_EVT_W-1:0] evt_sts_r, evt_sts_nxt;
  logic [SCL_EVT_W-1:0] evt_mask_r, evt_mask_nxt;

  // serial side state
  scl_state_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] txs_r, txs_nxt;
  logic [8:0] rxs_r, rxs_nxt;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic ack_bit_r, ack_bit_nxt;
  logic sclk_r, sclk_nxt;
  logic sdo_r, sdo_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [1:0] run_div_r, run_div_nxt;
  logic sin_s1_r, sin_s2_r, sin_s3_r, sin_v_r, sin_v_nxt;
  logic [3:0][1:0] cap_r, cap_nxt; // bits land late; rx byte may settle after busy drops at 1/2

  logic hit, fire, wr, rd, start_go, busy, tick, done_evt;
  logic [31:0] rd_mux;

  assign hit = wb_req_i.cyc & wb_req_i.stb;
  assign fire = hit & ack_r;
  assign wr = fire & wb_req_i.we & wb_req_i.sel[0];
  assign rd = fire & ~wb_req_i.we;
  assign busy = (st_r != SCL_ST_IDLE);
  // launches while a frame runs are dropped; the host spaces them out
  assign start_go = wr & (wb_req_i.adr == SCL_OFS_START) & armed_r & ~busy;
  assign done_evt = (st_r == SCL_ST_TAIL) & tick & (cnt_r == SCL_TAIL_TICKS - 5'h01);

  scl_clkdiv u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(busy),
    .ratio_i(run_div_r),
    .tick_o(tick)
  );

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_req_i.adr)
      SCL_OFS_TX_LO: rd_mux[7:0] = tx_r[7:0];
      SCL_OFS_TX_HI: rd_mux[7:0] = tx_r[15:8];
      SCL_OFS_RX: rd_mux[7:0] = rx_data_r;
      SCL_OFS_STAT: begin
        rd_mux[SCL_STAT_DIV_LSB +: 2] = div_sel_r;
        rd_mux[SCL_STAT_INTEN_BIT] = int_en_r;
        rd_mux[SCL_STAT_BUSY_BIT] = busy;
        rd_mux[SCL_STAT_ACKB_BIT] = ack_bit_r;
      end
      SCL_OFS_EVT_STS: rd_mux[SCL_EVT_W-1:0] = evt_sts_r;
      SCL_OFS_EVT_MASK: rd_mux[SCL_EVT_W-1:0] = evt_mask_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus group: one-wait-state slave, every access acked, unmapped reads zero
  always_comb begin
    ack_nxt = hit & ~ack_r;
    dat_nxt = (hit & ~ack_r) ? rd_mux : dat_r;
    tx_nxt = tx_r;
    div_sel_nxt = div_sel_r;
    int_en_nxt = int_en_r;
    armed_nxt = armed_r;
    evt_mask_nxt = evt_mask_r;
    evt_sts_nxt = evt_sts_r;
    if (wr) begin
      case (wb_req_i.adr)
        SCL_OFS_TX_LO: begin
          tx_nxt[7:0] = wb_req_i.dat[7:0];
          armed_nxt = 1'b1;
        end
        SCL_OFS_TX_HI: tx_nxt[15:8] = wb_req_i.dat[7:0];
        SCL_OFS_STAT: begin
          div_sel_nxt = wb_req_i.dat[SCL_STAT_DIV_LSB +: 2];
          int_en_nxt = wb_req_i.dat[SCL_STAT_INTEN_BIT];
        end
        SCL_OFS_EVT_STS: evt_sts_nxt = evt_sts_r & ~wb_req_i.dat[SCL_EVT_W-1:0];
        SCL_OFS_EVT_MASK: evt_mask_nxt = wb_req_i.dat[SCL_EVT_W-1:0];
        default: armed_nxt = armed_r;
      endcase
    end
    if (start_go) begin
      armed_nxt = 1'b0;
    end
    // a read between arming and launch cancels the standby
    if (rd) begin
      armed_nxt = 1'b0;
    end
    // hardware sets win over software clears
    if (done_evt) begin
      evt_sts_nxt[SCL_EVT_DONE] = 1'b1;
    end
    if (rd && armed_r) begin
      evt_sts_nxt[SCL_EVT_CANCEL] = 1'b1;
    end
    int_flag_nxt = int_flag_r;
    if (rd) begin
      int_flag_nxt = 1'b0;
    end
    if (!int_en_nxt) begin
      int_flag_nxt = 1'b0;
    end else if (done_evt && int_en_r) begin
      int_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      tx_r <= SCL_TX_RST;
      div_sel_r <= SCL_DIV_RST;
      int_en_r <= SCL_INTEN_RST;
      int_flag_r <= 1'b0;
      armed_r <= 1'b0;
      evt_sts_r <= SCL_EVT_RST;
      evt_mask_r <= SCL_EVT_RST;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      tx_r <= tx_nxt;
      div_sel_r <= div_sel_nxt;
      int_en_r <= int_en_nxt;
      int_flag_r <= int_flag_nxt;
      armed_r <= armed_nxt;
      evt_sts_r <= evt_sts_nxt;
      evt_mask_r <= evt_mask_nxt;
    end
  end

  // serial group
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    txs_nxt = txs_r;
    rxs_nxt = rxs_r;
    rx_data_nxt = rx_data_r;
    ack_bit_nxt = ack_bit_r;
    sclk_nxt = sclk_r;
    sdo_nxt = sdo_r;
    oe_n_nxt = oe_n_r;
    run_div_nxt = run_div_r;
    cap_nxt = {cap_r[2:0], 2'h0};
    // serial input only counts once the late stages agree
    sin_v_nxt = (sin_s2_r == sin_s3_r) ? sin_s3_r : sin_v_r;
    case (st_r)
      SCL_ST_IDLE: begin
        if (start_go) begin
          st_nxt = SCL_ST_LEAD;
          oe_n_nxt = 1'b0;
          txs_nxt = tx_r;
          run_div_nxt = div_sel_r;
          cnt_nxt = 5'h00;
        end
      end
      SCL_ST_LEAD: begin
        if (tick) begin
          st_nxt = SCL_ST_SHIFT;
          sclk_nxt = 1'b0;
          sdo_nxt = txs_r[15];
          txs_nxt = {txs_r[14:0], 1'b0};
          cnt_nxt = 5'h01;
        end
      end
      SCL_ST_SHIFT: begin
        if (tick && !sclk_r) begin
          sclk_nxt = 1'b1;
          cap_nxt[0] = {cnt_r == SCL_TX_BITS, cnt_r >= SCL_RX_FIRST};
          if (cnt_r == SCL_TX_BITS) begin
            st_nxt = SCL_ST_TAIL;
            cnt_nxt = 5'h00;
          end
        end else if (tick) begin
          sclk_nxt = 1'b0;
          sdo_nxt = txs_r[15];
          txs_nxt = {txs_r[14:0], 1'b0};
          cnt_nxt = cnt_r + 5'h01;
        end
      end
      SCL_ST_TAIL: begin
        if (tick) begin
          cnt_nxt = cnt_r + 5'h01;
        end
        if (done_evt) begin
          st_nxt = SCL_ST_IDLE;
          sdo_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          cnt_nxt = 5'h00;
        end
      end
      default: st_nxt = SCL_ST_IDLE;
    endcase
    if (cap_r[3][0]) begin
      rxs_nxt = {rxs_r[7:0], sin_v_r};
    end
    if (cap_r[3][1]) begin
      ack_bit_nxt = rxs_nxt[8];
      rx_data_nxt = rxs_nxt[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    sin_s1_r <= serial_data_in_i;
    sin_s2_r <= sin_s1_r;
    sin_s3_r <= sin_s2_r;
    if (rst_i) begin
      st_r <= SCL_ST_IDLE;
      cnt_r <= 5'h00;
      txs_r <= SCL_TX_RST;
      rxs_r <= 9'h000;
      rx_data_r <= SCL_RX_RST;
      ack_bit_r <= SCL_ACKB_RST;
      sclk_r <= 1'b1;
      sdo_r <= 1'b1;
      oe_n_r <= 1'b1;
      run_div_r <= SCL_DIV_RST;
      sin_v_r <= 1'b1;
      cap_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      txs_r <= txs_nxt;
      rxs_r <= rxs_nxt;
      rx_data_r <= rx_data_nxt;
      ack_bit_r <= ack_bit_nxt;
      sclk_r <= sclk_nxt;
      sdo_r <= sdo_nxt;
      oe_n_r <= oe_n_nxt;
      run_div_r <= run_div_nxt;
      sin_v_r <= sin_v_nxt;
      cap_r <= cap_nxt;
    end
  end

  // reset overrides the pins at once, not one edge later
  assign ser_o.sclk = sclk_r | rst_i;
  assign ser_o.serial_data_out = sdo_r | rst_i;
  assign ser_o.oe_n = oe_n_r | rst_i;
  assign int_o = int_flag_r;
  assign irq_o = |(evt_sts_r & evt_mask_r);
  assign wb_rsp_o.ack = ack_r;
  assign wb_rsp_o.dat = dat_r;

  // checking helpers
  logic [3:0] gap_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || (sclk_nxt != sclk_r)) begin
      gap_r <= 4'h0;
    end else begin
      gap_r <= gap_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_last_rise;
    (st_r == SCL_ST_SHIFT) && tick && !sclk_r && (cnt_r == SCL_TX_BITS);
  endsequence

  sequence s_idle_after;
    !busy && ser_o.oe_n && ser_o.serial_data_out;
  endsequence

  a_reset_pins_high: assert property (disable iff (1'b0)
    rst_i |-> (ser_o.sclk && ser_o.serial_data_out && ser_o.oe_n))
    else $error("pins not idle high during reset");

  a_reset_defaults: assert property (disable iff (1'b0)
    ($past(rst_i) && !rst_i) |-> (!busy && ack_bit_r && !int_o && div_sel_r == SCL_DIV_2))
    else $error("reset state wrong");

  a_sclk_half_period: assert property (
    ($changed(sclk_r) && st_r == SCL_ST_SHIFT && $past(st_r) == SCL_ST_SHIFT)
    |-> ($past(gap_r) == 4'((5'h01 << run_div_r) - 5'h01)))
    else $error("shift clock half period wrong");

  a_int_raise: assert property (
    (done_evt && int_en_r && !rd && $past(int_en_r)) |=> int_o)
    else $error("interrupt not raised at cycle end");

  a_int_read_clear: assert property (
    (rd && !done_evt) |=> !int_o)
    else $error("read did not clear interrupt");

  a_int_disabled_low: assert property (
    !int_en_r |-> !int_o)
    else $error("interrupt high while disabled");

  a_write_processed: assert property (
    (hit && wb_req_i.we && !ack_r) |-> ##[1:5] ack_r)
    else $error("write not processed in time");

  a_frame_tail: assert property (
    s_last_rise |-> ##1 (busy && ser_o.oe_n == 1'b0) ##[1:16] s_idle_after)
    else $error("frame did not end one bit after last rise");

  a_status_load: assert property (
    (wr && wb_req_i.adr == SCL_OFS_STAT)
    |=> (int_en_r == $past(wb_req_i.dat[SCL_STAT_INTEN_BIT])
         && div_sel_r == $past(wb_req_i.dat[1:0])))
    else $error("status write not loaded");

  a_ratio_frozen: assert property (
    (busy && $past(busy)) |-> $stable(run_div_r))
    else $error("divider ratio changed mid frame");

endmodule // scl_ctrl

// ==== tb/scl_periph.sv ====
// peripheral model on the serial side of the controller
`timescale 1ns/10ps
module scl_periph (
  input wire scl_pkg::scl_ser_t ser_i,
  input wire logic [8:0] pat_i,
  output logic serial_data_in_o,
  output logic [15:0] got_o
);
  import scl_pkg::*;
  int n;
  initial begin
    n = 0;
    serial_data_in_o = 1'b1;
    got_o = 16'h0000;
  end
  always @(negedge ser_i.oe_n) begin
    n = 0;
  end
  // lead bits carry nothing, so they toggle rather than hold
  always @(negedge ser_i.sclk) begin
    if (ser_i.oe_n === 1'b0) begin
      n = n + 1;
      if (n >= 8 && n <= 16)
        serial_data_in_o = pat_i[16-n];
      else
        serial_data_in_o = ~serial_data_in_o;
    end
  end
  always @(posedge ser_i.sclk) begin
    if (ser_i.oe_n === 1'b0)
      got_o = {got_o[14:0], ser_i.serial_data_out};
  end
  // released line shows the inverse of the last bit
  always @(posedge ser_i.oe_n) begin
    serial_data_in_o = ~serial_data_in_o;
  end
endmodule // scl_periph

// ==== tb/tb_top.sv ====
// self-checking bench for the serial bus controller
`timescale 1ns/10ps
module tb_top;
  import scl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  scl_wb_req_t wb_req = '0;
  scl_wb_rsp_t wb_rsp;
  scl_ser_t ser;
  logic serial_data_in;
  logic int_o;
  logic irq_o;
  logic [8:0] pat = 9'h000;
  logic [15:0] got;
  logic [31:0] rd;
  int err_count = 0;
  int tests_run = 0;
  int cyc_n = 0;
  int low_n = 0;
  int last_len = 0;
  int frames = 0;
  always #2 clk_i = ~clk_i;
  scl_ctrl u_scl_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .serial_data_in_i(serial_data_in), .ser_o(ser), .int_o(int_o), .irq_o(irq_o));
  scl_periph u_scl_periph (.ser_i(ser), .pat_i(pat), .serial_data_in_o(serial_data_in), .got_o(got));

  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [4:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_req <= {1'b1, 1'b1, we, adr, 4'hF, dat};
    n = 1;
    @(posedge clk_i);
    // no fixed latency is assumed; only the bench timeout ends this wait
    while (wb_rsp.ack !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    rd = wb_rsp.dat;
    if (we)
      chk("write processing", 32'h1, {31'h0, (n <= SCL_WR_PROC_TC)});
    wb_req <= '0;
  endtask

  // frame length is measured off oe_n so stalls in the bus tasks do not skew it
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (ser.oe_n === 1'b0)
      low_n <= low_n + 1;
    else if (low_n != 0) begin
      last_len <= low_n;
      low_n <= 0;
      frames <= frames + 1;
    end
    if (cyc_n == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic t_reset;
    repeat (8) @(posedge clk_i);
    chk("pins in reset", 32'h7, {29'h0, ser});
    chk("int in reset", {31'h0, int_o}, 32'h0);
    rst_i <= 1'b0;
    wb_xfer(1'b0, SCL_OFS_STAT, 32'h0);
    chk("status after reset", 32'h10, rd);
    wb_xfer(1'b0, 5'h1C, 32'h0);
    chk("unmapped read", 32'h0, rd);
    wb_xfer(1'b1, SCL_OFS_STAT, 32'h7);
    wb_xfer(1'b0, SCL_OFS_STAT, 32'h0);
    chk("status readback", 32'h17, rd);
  endtask

  task automatic run_frame(input logic [1:0] dv, input logic ie, input logic [1:0] dv2,
    input logic [15:0] tx, input logic [8:0] pt);
    int f0;
    pat <= pt;
    wb_xfer(1'b1, SCL_OFS_EVT_MASK, {31'h0, ie});
    wb_xfer(1'b1, SCL_OFS_STAT, {29'h0, ie, dv});
    wb_xfer(1'b1, SCL_OFS_TX_HI, {24'h0, tx[15:8]});
    wb_xfer(1'b1, SCL_OFS_TX_LO, {24'h0, tx[7:0]});
    f0 = frames;
    wb_xfer(1'b1, SCL_OFS_START, 32'h0);
    repeat (5) @(posedge clk_i);
    // ratio change mid-frame must not stretch this frame
    wb_xfer(1'b1, SCL_OFS_STAT, {29'h0, ie, dv2});
    while (frames == f0)
      @(posedge clk_i);
    chk("frame length", 32'd34 << dv, last_len);
    chk("serial word", {16'h0, tx}, {16'h0, got});
    repeat (2) @(posedge clk_i);
    chk("int pin", {31'h0, ie}, {31'h0, int_o});
    chk("event irq", {31'h0, ie}, {31'h0, irq_o});
    wb_xfer(1'b0, SCL_OFS_RX, 32'h0);
    chk("rx byte", {24'h0, pt[7:0]}, rd);
    @(posedge clk_i);
    chk("int after read", 32'h0, {31'h0, int_o});
    wb_xfer(1'b0, SCL_OFS_STAT, 32'h0);
    chk("status", {27'h0, pt[8], 1'b0, ie, dv2}, rd);
    wb_xfer(1'b0, SCL_OFS_EVT_STS, 32'h0);
    chk("event status", 32'h1, rd);
    wb_xfer(1'b1, SCL_OFS_EVT_STS, 32'h1);
    @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
  endtask

  task automatic t_cancel;
    int f0;
    f0 = frames;
    wb_xfer(1'b1, SCL_OFS_TX_LO, 32'h55);
    wb_xfer(1'b0, SCL_OFS_STAT, 32'h0);
    wb_xfer(1'b1, SCL_OFS_START, 32'h0);
    repeat (40) @(posedge clk_i);
    chk("no launch", f0, frames);
    wb_xfer(1'b0, SCL_OFS_EVT_STS, 32'h0);
    chk("cancel event", 32'h2, rd);
    wb_xfer(1'b1, SCL_OFS_EVT_STS, 32'h2);
  endtask

  initial begin
    t_reset();
    run_frame(2'h0, 1'b1, 2'h3, 16'hA5C3, 9'h15A);
    run_frame(2'h3, 1'b0, 2'h1, 16'h0F1E, 9'h0A5);
    run_frame(2'h1, 1'b1, 2'h2, 16'h8001, 9'h1FF);
    run_frame(2'h2, 1'b1, 2'h0, 16'h7FFE, 9'h100);
    t_cancel();
    wrap_up();
  end
endmodule // tb_top
